// ### core/wds_pkg.sv
// Package for the watchdog and sleep control block: map, fields, states, carriers
package wds_pkg;

  // APB byte offsets (printed offsets are not all multiples of four, so index*4)
  localparam logic [15:0] TIMER_CONFIG_IDX = 16'h0081;
  localparam logic [15:0] DEVICE_CONFIG_IDX = 16'h2007;
  localparam logic [15:0] STATUS_IDX = 16'h0003;
  localparam logic [15:0] IRQ_CONTROL_IDX = 16'h000B;
  localparam logic [15:0] CONTROL_IDX = 16'h0100;
  localparam logic [17:0] TIMER_CONFIG_ADDR = {TIMER_CONFIG_IDX, 2'b00};
  localparam logic [17:0] DEVICE_CONFIG_ADDR = {DEVICE_CONFIG_IDX, 2'b00};
  localparam logic [17:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
  localparam logic [17:0] IRQ_CONTROL_ADDR = {IRQ_CONTROL_IDX, 2'b00};
  localparam logic [17:0] CONTROL_ADDR = {CONTROL_IDX, 2'b00};

  // Field positions
  localparam int SCALER_OWNER_BIT = 3;
  localparam int RATIO_LSB = 0;
  localparam int WATCHDOG_FUSE_BIT = 2;
  localparam int EXPIRY_FLAG_BIT = 4;
  localparam int SLEEP_FLAG_BIT = 3;
  localparam int GLOBAL_IRQ_BIT = 7;

  // Reset values
  localparam logic [7:0] TIMER_CONFIG_RST = 8'hFF;
  localparam logic [7:0] DEVICE_CONFIG_RST = 8'hFF;
  localparam logic [7:0] IRQ_CONTROL_RST = 8'h00;

  // Timing: width of the basic watchdog counter, wake-to-vector dummy cycles
  localparam int WDT_COUNT_W = 8;
  localparam logic [WDT_COUNT_W-1:0] WDT_COUNT_MAX = 8'hFF;
  localparam logic [1:0] DUMMY_CYCLES = 2'h2;

  typedef enum logic [2:0] {
    WDS_RUN = 3'b000,
    WDS_ASLEEP = 3'b001,
    WDS_WAKE_EXEC = 3'b010,
    WDS_DUMMY = 3'b011
  } wds_state_type;

  // Core instruction events
  typedef struct packed {
    logic kick;
    logic sleep;
  } wds_op_type;

  // Wake sources, all already qualified by their own source flags
  typedef struct packed {
    logic ext_int;
    logic portb_change;
    logic periph;
  } wds_wake_type;

endpackage : wds_pkg

// ### core/wds_watchdog_sleep.sv
// Watchdog timer and sleep control with APB register access
module wds_watchdog_sleep (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic rc_tick_i,
  input wire logic external_reset_pin_n_i,
  input wire logic power_on_i,
  input wire wds_pkg::wds_op_type op_i,
  input wire wds_pkg::wds_wake_type wake_req_i,
  input wire logic pending_irq_i,
  input wire logic [7:0] pin_drive_i,
  input wire logic [7:0] pin_oe_n_i,
  input wire logic [31:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic device_reset_o,
  output logic osc_enable_o,
  output logic cpu_hold_o,
  output logic prefetch_next_o,
  output logic vector_fetch_o,
  output logic dummy_cycle_o,
  output logic [7:0] pin_drive_o,
  output logic [7:0] pin_oe_n_o
);
  import wds_pkg::*;

  logic [7:0] timer_config_r;
  logic [7:0] device_config_r;
  logic [7:0] irq_control_r;
  logic expiry_flag_n_r;
  logic sleep_entered_flag_n_r;
  logic [WDT_COUNT_W-1:0] wdt_count_r;
  logic [6:0] postscaler_r;
  logic [1:0] dummy_cnt_r;
  wds_state_type state_r;
  wds_state_type state_nxt;
  logic tick_s1_r;
  logic tick_s2_r;
  logic tick_s3_r;
  logic rst_s1_r;
  logic rst_s2_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic [2:0] wake_s1_r;
  logic [2:0] wake_s2_r;
  logic [7:0] drive_hold_r;
  logic [7:0] oe_n_hold_r;
  logic rd_en;
  logic wr_en;
  logic [7:0] rd_byte;
  logic addr_hit;
  logic tick_pulse;
  logic wdt_enabled;
  logic scaler_to_wdt;
  logic wdt_clear;
  logic base_expire;
  logic post_expire;
  logic wdt_expire;
  logic sleep_exec;
  logic sleep_nop;
  logic wake_irq;
  logic [7:0] ratio_mask;

  // Ratio bits to postscaler terminal mask, 2^n expiries per time-out
  function automatic logic [7:0] ratio_to_mask(input logic [2:0] ratio);
    ratio_to_mask = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(ratio)) begin
        ratio_to_mask[i] = 1'b1;
      end
    end
  endfunction

  // Address decode shared by read mux and write paths
  function automatic logic is_addr(input logic [31:0] a, input logic [17:0] reg_addr);
    is_addr = (a[31:18] == 14'h0000) && (a[17:0] == reg_addr);
  endfunction

  // Synchronisers for the RC tick, the reset pin, the pending interrupt and wake inputs; stage two is read, and for the tick stage three too
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      tick_s1_r <= 1'b0;
      tick_s2_r <= 1'b0;
      tick_s3_r <= 1'b0;
      rst_s1_r <= 1'b1;
      rst_s2_r <= 1'b1;
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
      wake_s1_r <= 3'h0;
      wake_s2_r <= 3'h0;
    end else begin
      tick_s1_r <= rc_tick_i;
      tick_s2_r <= tick_s1_r;
      tick_s3_r <= tick_s2_r;
      rst_s1_r <= external_reset_pin_n_i;
      rst_s2_r <= rst_s1_r;
      irq_s1_r <= pending_irq_i;
      irq_s2_r <= irq_s1_r;
      wake_s1_r <= wake_req_i;
      wake_s2_r <= wake_s1_r;
    end
  end

  // The RC tick runs free of the main clock, so counting goes on while the core is held
  assign tick_pulse = tick_s2_r & ~tick_s3_r;
  assign wdt_enabled = device_config_r[WATCHDOG_FUSE_BIT];
  assign scaler_to_wdt = timer_config_r[SCALER_OWNER_BIT];
  assign ratio_mask = ratio_to_mask(timer_config_r[RATIO_LSB +: 3]);
  assign base_expire = wdt_enabled && tick_pulse && (wdt_count_r == WDT_COUNT_MAX);
  assign post_expire = !scaler_to_wdt || ((postscaler_r & ratio_mask[6:0]) == ratio_mask[6:0]);
  assign wdt_expire = base_expire && post_expire && !wdt_clear;

  // Sleep runs only from RUN; a pending enabled interrupt turns it into a no-op
  assign sleep_exec = op_i.sleep && (state_r == WDS_RUN) && !irq_s2_r;
  assign sleep_nop = op_i.sleep && (state_r == WDS_RUN) && irq_s2_r;
  assign wdt_clear = op_i.kick || sleep_exec;
  // Wake sources arrive already gated by their individual enables; global enable not needed
  assign wake_irq = |wake_s2_r;

  // Watchdog base counter and postscaler
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wdt_count_r <= '0;
      postscaler_r <= 7'h00;
    end else if (wdt_clear || !wdt_enabled) begin
      wdt_count_r <= '0;
      postscaler_r <= 7'h00;
    end else if (tick_pulse) begin
      wdt_count_r <= wdt_count_r + 1'b1;
      if (wdt_count_r == WDT_COUNT_MAX && scaler_to_wdt) begin
        postscaler_r <= post_expire ? 7'h00 : postscaler_r + 7'h01;
      end
    end
  end

  // Sleep/wake sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      WDS_RUN: begin
        if (sleep_exec) begin
          state_nxt = WDS_ASLEEP;
        end
      end
      WDS_ASLEEP: begin
        // An interrupt arriving mid-sleep still lets sleep finish, then wakes at once
        if (wdt_expire || wake_irq || irq_s2_r) begin
          state_nxt = WDS_WAKE_EXEC;
        end
      end
      WDS_WAKE_EXEC: begin
        if (irq_control_r[GLOBAL_IRQ_BIT] && (wake_irq || irq_s2_r)) begin
          state_nxt = WDS_DUMMY;
        end else begin
          state_nxt = WDS_RUN;
        end
      end
      WDS_DUMMY: begin
        if (dummy_cnt_r == DUMMY_CYCLES - 2'h1) begin
          state_nxt = WDS_RUN;
        end
      end
      default: state_nxt = WDS_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !rst_s2_r) begin
      state_r <= WDS_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Dummy-cycle counter before vector fetch
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || state_r != WDS_DUMMY) begin
      dummy_cnt_r <= 2'h0;
    end else begin
      dummy_cnt_r <= dummy_cnt_r + 2'h1;
    end
  end

  // Status flags; a sleep in the expiry cycle suppresses the expiry, so the sleep set wins
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || power_on_i) begin
      expiry_flag_n_r <= 1'b1;
      sleep_entered_flag_n_r <= 1'b1;
    end else begin
      if (wdt_expire) begin
        expiry_flag_n_r <= 1'b0;
      end else if (sleep_exec) begin
        expiry_flag_n_r <= 1'b1;
      end else if (op_i.kick) begin
        expiry_flag_n_r <= 1'b1;
      end
      if (sleep_exec) begin
        sleep_entered_flag_n_r <= 1'b0;
      end else if (op_i.kick) begin
        sleep_entered_flag_n_r <= 1'b1;
      end
    end
  end

  // Pin state captured at sleep entry and held while asleep
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      drive_hold_r <= 8'h00;
      oe_n_hold_r <= 8'hFF;
    end else if (state_r != WDS_ASLEEP) begin
      drive_hold_r <= pin_drive_i;
      oe_n_hold_r <= pin_oe_n_i;
    end
  end

  // Core-facing outputs registered where they carry data
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      device_reset_o <= 1'b0;
      pin_drive_o <= 8'h00;
      pin_oe_n_o <= 8'hFF;
    end else begin
      device_reset_o <= (wdt_expire && state_r != WDS_ASLEEP) || !rst_s2_r;
      pin_drive_o <= drive_hold_r;
      pin_oe_n_o <= oe_n_hold_r;
    end
  end

  assign osc_enable_o = (state_r != WDS_ASLEEP);
  assign cpu_hold_o = (state_r == WDS_ASLEEP) || (state_r == WDS_DUMMY);
  assign prefetch_next_o = sleep_exec || sleep_nop;
  assign dummy_cycle_o = (state_r == WDS_DUMMY);
  assign vector_fetch_o = (state_r == WDS_DUMMY) && (state_nxt == WDS_RUN);

  // APB slave: zero wait states, error on unmapped addresses
  assign addr_hit = is_addr(paddr_i, TIMER_CONFIG_ADDR) || is_addr(paddr_i, DEVICE_CONFIG_ADDR)
    || is_addr(paddr_i, STATUS_ADDR) || is_addr(paddr_i, IRQ_CONTROL_ADDR)
    || is_addr(paddr_i, CONTROL_ADDR);
  assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0] && addr_hit;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_hit;

  // Writable registers; kick never touches the owner bit
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      timer_config_r <= TIMER_CONFIG_RST;
      device_config_r <= DEVICE_CONFIG_RST;
      irq_control_r <= IRQ_CONTROL_RST;
    end else if (wr_en) begin
      if (is_addr(paddr_i, TIMER_CONFIG_ADDR)) begin
        timer_config_r <= pwdata_i[7:0];
      end
      if (is_addr(paddr_i, DEVICE_CONFIG_ADDR)) begin
        device_config_r <= pwdata_i[7:0];
      end
      if (is_addr(paddr_i, IRQ_CONTROL_ADDR)) begin
        irq_control_r <= pwdata_i[7:0];
      end
    end
  end

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    if (is_addr(paddr_i, TIMER_CONFIG_ADDR)) begin
      rd_byte = timer_config_r;
    end else if (is_addr(paddr_i, DEVICE_CONFIG_ADDR)) begin
      rd_byte = device_config_r;
    end else if (is_addr(paddr_i, IRQ_CONTROL_ADDR)) begin
      rd_byte = irq_control_r;
    end else if (is_addr(paddr_i, STATUS_ADDR)) begin
      rd_byte[EXPIRY_FLAG_BIT] = expiry_flag_n_r;
      rd_byte[SLEEP_FLAG_BIT] = sleep_entered_flag_n_r;
    end else if (is_addr(paddr_i, CONTROL_ADDR)) begin
      rd_byte = {5'h00, state_r};
    end
  end

  // Read data registered so it stays stable after the access
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= {24'h000000, rd_byte};
    end else if (rd_en) begin
      prdata_o <= prdata_o;
    end
  end

endmodule // wds_watchdog_sleep

// ### dv/wds_assertions.sv
// Port checker for the watchdog and sleep control block
module wds_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic external_reset_pin_n_i,
  input wire wds_pkg::wds_op_type op_i,
  input wire logic [31:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic device_reset_o,
  input wire logic osc_enable_o,
  input wire logic cpu_hold_o,
  input wire logic prefetch_next_o,
  input wire logic vector_fetch_o,
  input wire logic dummy_cycle_o,
  input wire logic [7:0] pin_drive_o
);
  import wds_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Decode of the five mapped words
  wire logic mapped = (paddr_i[31:18] == 14'h0) && (paddr_i[17:0] inside {TIMER_CONFIG_ADDR,
    DEVICE_CONFIG_ADDR, STATUS_ADDR, IRQ_CONTROL_ADDR, CONTROL_ADDR});
  apb_ready_a: assert property (psel_i && penable_i |-> pready_o)
    else $error("access not answered");
  unmapped_err_a: assert property (psel_i && penable_i |-> pslverr_o == !mapped)
    else $error("error response wrong");
  osc_hold_a: assert property (!osc_enable_o |-> cpu_hold_o)
    else $error("core runs with oscillator off");
  osc_cause_a: assert property ($fell(osc_enable_o) |-> $past(op_i.sleep))
    else $error("oscillator stopped without sleep");
  pin_freeze_a: assert property (!$past(osc_enable_o) |-> $stable(pin_drive_o))
    else $error("pins moved while asleep");
  prefetch_src_a: assert property (prefetch_next_o |-> op_i.sleep)
    else $error("prefetch without sleep");
  dummy_len_a: assert property ($rose(dummy_cycle_o) |-> dummy_cycle_o [*2] ##1 !dummy_cycle_o)
    else $error("dummy cycle count wrong");
  vector_slot_a: assert property (vector_fetch_o |-> dummy_cycle_o && $past(dummy_cycle_o))
    else $error("vector fetch out of place");
  asleep_reset_a: assert property (!osc_enable_o && $past(external_reset_pin_n_i, 3)
    |-> !device_reset_o) else $error("reset while asleep");
  // Main scenarios reached
  cover property ($fell(osc_enable_o));
  cover property ($rose(dummy_cycle_o));
  cover property ($rose(device_reset_o));
endmodule : wds_checker

bind wds_watchdog_sleep wds_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .external_reset_pin_n_i(external_reset_pin_n_i), .op_i(op_i), .paddr_i(paddr_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .device_reset_o(device_reset_o), .osc_enable_o(osc_enable_o), .cpu_hold_o(cpu_hold_o),
  .prefetch_next_o(prefetch_next_o), .vector_fetch_o(vector_fetch_o),
  .dummy_cycle_o(dummy_cycle_o), .pin_drive_o(pin_drive_o));

// ### dv/watchdog_and_sleep_control_tb.sv
// Self-checking bench for the watchdog and sleep control block
module watchdog_and_sleep_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import wds_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, rc_tick_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic pwrite_i = 1'b0, pending_irq_i = 1'b0, tick_on = 1'b0, e, pf, ext_rst_n = 1'b1;
  logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, q;
  logic [7:0] pin_drive_i = 8'hA5, pin_drive_o, pin_oe_n_i = 8'h0F, pin_oe_n_o;
  logic pready_o, pslverr_o, device_reset_o, osc_enable_o, cpu_hold_o;
  logic prefetch_next_o, vector_fetch_o, dummy_cycle_o;
  wds_op_type op_i = '0;
  wds_wake_type wake_req_i = '0;
  int num_errors = 0, tests_run = 0, n, nrst = 0, ndum = 0, nvec = 0;

  wds_watchdog_sleep DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .rc_tick_i(rc_tick_i),
    .external_reset_pin_n_i(ext_rst_n), .power_on_i(1'b0), .op_i(op_i), .wake_req_i(wake_req_i),
    .pending_irq_i(pending_irq_i), .pin_drive_i(pin_drive_i), .pin_oe_n_i(pin_oe_n_i),
    .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .device_reset_o(device_reset_o), .osc_enable_o(osc_enable_o),
    .cpu_hold_o(cpu_hold_o), .prefetch_next_o(prefetch_next_o),
    .vector_fetch_o(vector_fetch_o), .dummy_cycle_o(dummy_cycle_o),
    .pin_drive_o(pin_drive_o), .pin_oe_n_o(pin_oe_n_o));

  initial forever #2.5 clk_i = ~clk_i;
  // Watchdog RC stand-in: one rising edge every two clocks while enabled
  always @(posedge clk_i) if (tick_on) rc_tick_i <= ~rc_tick_i;
  // Event counters, cleared by the scenarios that read them
  always @(posedge clk_i) begin
    if (device_reset_o === 1'b1) nrst++;
    if (dummy_cycle_o === 1'b1) ndum++;
    if (vector_fetch_o === 1'b1) nvec++;
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {14'h0, a};
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [7:0] ex, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, ex}, q);
  endtask
  // Status flags as {expiry_flag_n, sleep_entered_flag_n}
  task automatic st(input logic [1:0] ex);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("status", {30'h0, ex}, {30'h0, q[4:3]});
  endtask
  // One-cycle instruction pulse; prefetch is sampled inside the pulse
  task automatic op(input logic k, input logic s);
    @(posedge clk_i);
    op_i <= '{kick: k, sleep: s};
    #1 pf = prefetch_next_o;
    @(posedge clk_i);
    op_i <= '0;
    #1;
  endtask
  task automatic wait_wake(input int lim);
    n = 0;
    while (osc_enable_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic t_regs();
    rd(TIMER_CONFIG_ADDR, TIMER_CONFIG_RST, "timer_config");
    rd(DEVICE_CONFIG_ADDR, DEVICE_CONFIG_RST, "device_config");
    rd(IRQ_CONTROL_ADDR, 8'h00, "irq_control");
    st(2'b11);
    apb(1'b0, 18'h00010, 32'h0);
    chk("unmapped", 1, {31'h0, e});
    $display("regs done");
  endtask
  // Owner bit and ratio decide the expiry time; a kick restarts it
  task automatic t_wdt();
    logic [7:0] cfg [3] = '{8'h08, 8'h09, 8'h07};
    int cyc [3] = '{512, 1024, 512};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, TIMER_CONFIG_ADDR, {24'h0, cfg[i]});
      op(1'b1, 1'b0);
      tick_on <= 1'b1;
      repeat (400) @(posedge clk_i);
      op(1'b1, 1'b0);
      n = 0;
      while (device_reset_o !== 1'b1 && n < 1500) begin
        @(posedge clk_i);
        n++;
      end
      tick_on <= 1'b0;
      chk("expiry_time", 1, {31'h0, n >= cyc[i] - 8 && n <= cyc[i] + 24});
      st(2'b01);
      rd(TIMER_CONFIG_ADDR, cfg[i], "owner_kept");
    end
    $display("watchdog done");
  endtask
  task automatic t_sleep();
    for (int g = 0; g < 2; g++) begin
      apb(1'b1, IRQ_CONTROL_ADDR, g ? 32'h80 : 32'h0);
      pin_drive_i <= 8'hA5;
      pin_oe_n_i <= 8'h0F;
      op(1'b1, 1'b0);
      op(1'b0, 1'b1);
      chk("prefetch", 1, {31'h0, pf});
      chk("osc_off", 0, {31'h0, osc_enable_o});
      chk("core_held", 1, {31'h0, cpu_hold_o});
      @(posedge clk_i);
      pin_drive_i <= 8'h5A;
      pin_oe_n_i <= 8'hF0;
      st(2'b10);
      chk("pins_held", 32'hA5, {24'h0, pin_drive_o});
      chk("oe_held", 32'h0F, {24'h0, pin_oe_n_o});
      ndum = 0;
      nvec = 0;
      wake_req_i <= g ? 3'b001 : 3'b100;
      wait_wake(20);
      chk("woken", 1, {31'h0, osc_enable_o});
      wake_req_i <= '0;
      repeat (6) @(posedge clk_i);
      chk("dummies", g ? 2 : 0, ndum);
      chk("vector", g, nvec);
      chk("pins_follow", 32'h5A, {24'h0, pin_drive_o});
      chk("oe_follow", 32'hF0, {24'h0, pin_oe_n_o});
    end
    $display("sleep done");
  endtask
  task automatic t_pend();
    pending_irq_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    // Kick first so that a sleep which wrongly ran would show in the flags
    op(1'b1, 1'b0);
    op(1'b0, 1'b1);
    chk("nop_prefetch", 1, {31'h0, pf});
    chk("nop_awake", 1, {31'h0, osc_enable_o});
    st(2'b11);
    pending_irq_i <= 1'b0;
    $display("pending done");
  endtask
  task automatic t_sleep_wdt();
    apb(1'b1, TIMER_CONFIG_ADDR, 32'h08);
    op(1'b1, 1'b0);
    nrst = 0;
    tick_on <= 1'b1;
    op(1'b0, 1'b1);
    wait_wake(700);
    tick_on <= 1'b0;
    chk("wdt_wake", 1, {31'h0, n >= 496 && n <= 540});
    chk("no_reset", 0, nrst);
    st(2'b00);
    $display("sleep expiry done");
  endtask
  // Reset pin while asleep: full reset and the core runs again
  task automatic t_pin_reset();
    op(1'b1, 1'b0);
    op(1'b0, 1'b1);
    nrst = 0;
    @(posedge clk_i);
    ext_rst_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    ext_rst_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("pin_reset", 1, {31'h0, nrst > 0});
    chk("pin_wake", 1, {31'h0, osc_enable_o});
    $display("pin reset done");
  endtask
  task automatic t_fuse();
    rd(DEVICE_CONFIG_ADDR, 8'hFF, "fuse_on");
    apb(1'b1, DEVICE_CONFIG_ADDR, 32'hFB);
    rd(DEVICE_CONFIG_ADDR, 8'hFB, "fuse_off");
    op(1'b1, 1'b0);
    nrst = 0;
    tick_on <= 1'b1;
    repeat (1200) @(posedge clk_i);
    tick_on <= 1'b0;
    chk("fuse_no_reset", 0, nrst);
    $display("fuse done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard, well past the expected run length
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    t_regs();
    t_wdt();
    t_sleep();
    t_pend();
    t_sleep_wdt();
    t_pin_reset();
    t_fuse();
    close_out();
  end
endmodule : watchdog_and_sleep_control_tb
